// [core/mrlf_top.sv]
// monitor result formatting, limit flags, fault pins and resistor selection
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - conversion sets its channel's done bit
// - alarm and warning flags per channel
// - per-channel enable of limit indication
// - results are 16-bit, left-justified thirteen bits
// - three result LSBs forced to zero
// - channels refreshed round-robin each frame
// - frame period typically 47 ms, max 60
// - limit compare runs automatically, no command
// - flags set within bounded time
// - voltages unsigned, temperature two's complement
// - codes span 8000..7ff8 and 0000..fff8
// - temperature high byte degrees, low fraction
// - count weights 100 uV and 38.147 uV
// - fault pin asserts on alarm limit violation too
// - two buffers drive open-drain outputs
// - resistor positions set independently
// - lookup per 2 degrees, -40 to 102
// - index enable low selects manual positions
module mrlf_top import mrlf_pkg::*; #(
   parameter int FRAME_CYCLES = FRAME_CYC_TYP // one frame of five slots
) (
   input wire logic sys_clk, // 50 MHz clock
   input wire logic arst_n, // async reset
   input wire logic [11:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [11:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   output mrlf_adc_req_s adcReq, // conversion request pulse
   input wire mrlf_adc_rsp_s adcRsp, // conversion result pulse
   input wire logic faultBufferIn, // fault buffer pin
   input wire logic losBufferIn, // loss buffer pin
   output logic faultOpenDrainOut, // fault pin level when driven
   output logic faultOpenDrainOe_n, // fault pin pull-down enable
   output logic losOpenDrainOut, // loss pin level when driven
   output logic losOpenDrainOe_n, // loss pin pull-down enable
   output logic [1:0][7:0] resPos // resistor positions
);
   localparam int SLOT = FRAME_CYCLES / NCH;
   localparam logic [31:0] SLOT_LAST = 32'(SLOT - 1);

   logic awReady_q, wReady_q, awHeld_q, wHeld_q, bValid_q, arReady_q, rValid_q;
   logic [11:0] awAddr_q;
   logic [31:0] wData_q, rData_q;
   logic [3:0] wStrb_q;
   logic [1:0] bResp_q, rResp_q;
   logic ctrlTen_q;
   logic [4:0] ctrlFen_q, done_q;
   logic [15:0] man_q;
   logic [15:0] res_q [NCH];
   logic [15:0] lim_q [4*NCH];
   logic [7:0] lut_q [2][LUT_N];
   logic [1:0][7:0] pos_q;
   mrlf_flags_s flags_q, cmpFlags;
   logic [31:0] slotCnt_q;
   logic [2:0] ch_q, pendCh_q;
   mrlf_adc_req_s adcReq_q;
   logic [1:0] faultSync_q, losSync_q;
   logic faultOe_q, losOe_q, odOut_q;

   function automatic logic addrOk(input logic [11:0] a);
      logic [2:0] g;
      logic [2:0] x;
      g = a[7:5];
      x = a[4:2];
      case (a[11:9])
         PAGE_REG: addrOk = !a[8] && (g == GRP_CFG ? x <= IDX_POS
                                                   : (g <= GRP_LIM_END && x <= CH_LAST));
         PAGE_LUT0, PAGE_LUT1: addrOk = a[8:2] <= LUT_LAST;
         default: addrOk = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // bus handshakes
   wire logic awTake = s_axi_awvalid & awReady_q;
   wire logic wTake = s_axi_wvalid & wReady_q;
   wire logic doWrite = awHeld_q & wHeld_q & !bValid_q;
   wire logic awHeldD = doWrite ? 1'b0 : (awHeld_q | awTake);
   wire logic wHeldD = doWrite ? 1'b0 : (wHeld_q | wTake);
   wire logic arTake = s_axi_arvalid & arReady_q;
   wire logic rValidD = arTake | (rValid_q & !s_axi_rready);

   // write decode
   wire logic [2:0] wPage = awAddr_q[11:9];
   wire logic [2:0] wGrp = awAddr_q[7:5];
   wire logic [2:0] wIdx = awAddr_q[4:2];
   wire logic [6:0] wLut = awAddr_q[8:2];
   wire logic [4:0] wLimK = ({2'b00, wGrp} - 5'd2) * 5'd5 + {2'b00, wIdx};
   wire logic wOk = addrOk(awAddr_q);
   wire logic wCfg = doWrite & wOk & (wPage == PAGE_REG) & (wGrp == GRP_CFG);
   wire logic wrCtrl = wCfg & (wIdx == IDX_CTRL);
   wire logic wrStat = wCfg & (wIdx == IDX_STAT) & wStrb_q[0];
   wire logic wrMan = wCfg & (wIdx == IDX_MAN);
   wire logic wrLim = doWrite & wOk & (wPage == PAGE_REG) & (wGrp >= GRP_LIM);
   wire logic wrLut0 = doWrite & wOk & (wPage == PAGE_LUT0) & wStrb_q[0];
   wire logic wrLut1 = doWrite & wOk & (wPage == PAGE_LUT1) & wStrb_q[0];

   // read decode
   wire logic [2:0] rPage = s_axi_araddr[11:9];
   wire logic [2:0] rGrp = s_axi_araddr[7:5];
   wire logic [2:0] rIdx = s_axi_araddr[4:2];
   wire logic [6:0] rLut = s_axi_araddr[8:2];
   wire logic [4:0] rLimK = ({2'b00, rGrp} - 5'd2) * 5'd5 + {2'b00, rIdx};
   wire logic rOk = addrOk(s_axi_araddr);
   wire logic [31:0] ctrlWord = {19'h0, ctrlFen_q, 7'h0, ctrlTen_q};
   wire logic [31:0] flagWord = {3'h0, flags_q.wLo, 3'h0, flags_q.wHi,
                                 3'h0, flags_q.aLo, 3'h0, flags_q.aHi};
   wire logic [31:0] rdCfg = rIdx == IDX_CTRL ? ctrlWord
                           : rIdx == IDX_STAT ? {27'h0, done_q}
                           : rIdx == IDX_FLAG ? flagWord
                           : rIdx == IDX_MAN ? {16'h0, man_q}
                           : {16'h0, pos_q};
   wire logic [31:0] rdReg = rGrp == GRP_CFG ? rdCfg
                           : rGrp == GRP_RES ? {16'h0, res_q[rIdx]}
                           : {16'h0, lim_q[rLimK]};
   wire logic [31:0] rdAll = !rOk ? 32'h0
                           : rPage == PAGE_REG ? rdReg
                           : {24'h0, lut_q[rPage == PAGE_LUT1][rLut]};

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         awReady_q <= 1'b1;
         wReady_q <= 1'b1;
         awHeld_q <= 1'b0;
         wHeld_q <= 1'b0;
         awAddr_q <= 12'h000;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else begin
         awHeld_q <= awHeldD;
         wHeld_q <= wHeldD;
         awReady_q <= !awHeldD;
         wReady_q <= !wHeldD;
         if (awTake) begin
            awAddr_q <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite) begin
            bValid_q <= 1'b1;
            bResp_q <= wOk ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         arReady_q <= 1'b1;
         rValid_q <= 1'b0;
         rData_q <= 32'h0;
         rResp_q <= RESP_OKAY;
      end else begin
         rValid_q <= rValidD;
         arReady_q <= !rValidD;
         if (arTake) begin
            rData_q <= rdAll;
            rResp_q <= rOk ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // round-robin conversion slots, five per frame
   wire logic slotEnd = slotCnt_q == SLOT_LAST;
   wire logic rspFire = adcRsp.valid;
   wire logic [4:0] doneSet = rspFire ? 5'h01 << pendCh_q : 5'h00;
   wire logic [4:0] doneClr = wrStat ? wData_q[4:0] : 5'h00;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         slotCnt_q <= 32'h0;
         ch_q <= 3'h0;
         pendCh_q <= 3'h0;
         adcReq_q <= '0;
         done_q <= 5'h00;
      end else begin
         slotCnt_q <= slotEnd ? 32'h0 : slotCnt_q + 32'h1;
         if (slotEnd) begin
            ch_q <= (ch_q == CH_LAST) ? 3'h0 : ch_q + 3'h1;
            pendCh_q <= ch_q;
         end
         adcReq_q <= '{valid: slotEnd, ch: ch_q};
         done_q <= (done_q & ~doneClr) | doneSet;
      end
   end

   // results: twelve-plus bits kept, low three always zero
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NCH; i++) begin
            res_q[i] <= RES_RST;
         end
      end else if (rspFire) begin
         res_q[pendCh_q] <= adcRsp.code & RES_MASK;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrlTen_q <= CTRL_TEN_RST;
         ctrlFen_q <= CTRL_FEN_RST;
         man_q <= MAN_RST;
         for (int k = 0; k < 4 * NCH; k++) begin
            lim_q[k] <= lim_rst(k);
         end
      end else begin
         if (wrCtrl && wStrb_q[0]) begin
            ctrlTen_q <= wData_q[CTRL_TEN_BIT];
         end
         if (wrCtrl && wStrb_q[1]) begin
            ctrlFen_q <= wData_q[CTRL_FEN_LSB +: 5];
         end
         if (wrMan) begin
            man_q <= merge16(man_q, wData_q, wStrb_q);
         end
         if (wrLim) begin
            lim_q[wLimK] <= merge16(lim_q[wLimK], wData_q, wStrb_q);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int t = 0; t < LUT_N; t++) begin
            lut_q[0][t] <= LUT_RST;
            lut_q[1][t] <= LUT_RST;
         end
      end else begin
         if (wrLut0) begin
            lut_q[0][wLut] <= wData_q[7:0];
         end
         if (wrLut1) begin
            lut_q[1][wLut] <= wData_q[7:0];
         end
      end
   end

   // per-channel limit compare, temperature signed
   for (genvar i = 0; i < NCH; i++) begin : g_cmp
      mrlf_cmp u_cmp (
         .value(res_q[i]),
         .isSigned(3'(i) == CH_TEMP),
         .aHiLim(lim_q[i]),
         .aLoLim(lim_q[NCH + i]),
         .wHiLim(lim_q[2 * NCH + i]),
         .wLoLim(lim_q[3 * NCH + i]),
         .aHi(cmpFlags.aHi[i]),
         .aLo(cmpFlags.aLo[i]),
         .wHi(cmpFlags.wHi[i]),
         .wLo(cmpFlags.wLo[i])
      );
   end

   // temperature whole degrees in the upper byte, 2 degree steps from -40
   wire logic [7:0] tWhole = res_q[CH_TEMP][15:8];
   wire logic [8:0] tSum = {tWhole[7], tWhole} + TEMP_OFS;
   wire logic [6:0] lutIdx = tSum[8] ? 7'h00
                           : (tSum[7:1] > LUT_LAST ? LUT_LAST : tSum[7:1]);
   wire logic [4:0] limViol = ctrlFen_q & (flags_q.aHi | flags_q.aLo);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flags_q <= '0;
         pos_q <= {POS_RST, POS_RST};
         faultSync_q <= 2'b00;
         losSync_q <= 2'b00;
         faultOe_q <= 1'b0;
         losOe_q <= 1'b0;
         odOut_q <= 1'b0;
      end else begin
         flags_q <= cmpFlags;
         for (int r = 0; r < 2; r++) begin
            pos_q[r] <= ctrlTen_q ? lut_q[r][lutIdx] : man_q[r * 8 +: 8];
         end
         faultSync_q <= {faultSync_q[0], faultBufferIn};
         losSync_q <= {losSync_q[0], losBufferIn};
         faultOe_q <= faultSync_q[1] | (|limViol);
         losOe_q <= losSync_q[1];
         odOut_q <= 1'b0;
      end
   end

   assign s_axi_awready = awReady_q;
   assign s_axi_wready = wReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;
   assign adcReq = adcReq_q;
   assign faultOpenDrainOut = odOut_q;
   assign faultOpenDrainOe_n = faultOe_q;
   assign losOpenDrainOut = odOut_q;
   assign losOpenDrainOe_n = losOe_q;
   assign resPos = pos_q;

   // checking helpers
   logic [31:0] gapCnt_q;
   logic seenReq_q;
   logic [2:0] lastCh_q;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gapCnt_q <= 32'h0;
         seenReq_q <= 1'b0;
         lastCh_q <= 3'h0;
      end else begin
         gapCnt_q <= adcReq_q.valid ? 32'h0 : gapCnt_q + 32'h1;
         if (adcReq_q.valid) begin
            seenReq_q <= 1'b1;
            lastCh_q <= adcReq_q.ch;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   done_set_a: assert property (rspFire |=> done_q[$past(pendCh_q)])
      else $error("done bit not set after conversion");
   result_mask_a: assert property (rspFire |=>
      res_q[$past(pendCh_q)] == {$past(adcRsp.code[15:3]), 3'h0})
      else $error("result not stored masked");
   seq_order_a: assert property (adcReq_q.valid && seenReq_q |->
      adcReq_q.ch == ((lastCh_q == CH_LAST) ? 3'h0 : lastCh_q + 3'h1))
      else $error("channel order broken");
   slot_gap_a: assert property (adcReq_q.valid && seenReq_q |-> gapCnt_q == SLOT_LAST)
      else $error("slot length wrong");
   // a limit written on the storing edge would change the expected flag
   alarm_hi_a: assert property (rspFire && pendCh_q != CH_TEMP && !doWrite &&
      adcRsp.code[15:3] > lim_q[pendCh_q][15:3] |=> ##1 flags_q.aHi[$past(pendCh_q, 2)])
      else $error("alarm high flag late");
   temp_sign_a: assert property (rspFire && pendCh_q == CH_TEMP && adcRsp.code[15] &&
      !lim_q[NCH + 4][15] && !doWrite |=> ##1 flags_q.aLo[CH_TEMP])
      else $error("negative temperature not below limit");
   stat_clear_a: assert property (wrStat && !rspFire |=>
      (done_q & $past(wData_q[4:0])) == 5'h00)
      else $error("done bits not cleared");
   fault_pin_a: assert property (##1 faultOpenDrainOe_n ==
      $past(faultSync_q[1] | (|(ctrlFen_q & (flags_q.aHi | flags_q.aLo)))))
      else $error("fault pin wrong");
   los_pin_a: assert property (##1 losOpenDrainOe_n == $past(losSync_q[1]) &&
      !losOpenDrainOut)
      else $error("loss buffer pin wrong");
   manual_pos_a: assert property (!ctrlTen_q |=> resPos == $past(man_q))
      else $error("manual positions not held");
   lut_pos_a: assert property (ctrlTen_q |=>
      resPos[1] == $past(lut_q[1][lutIdx]) && resPos[0] == $past(lut_q[0][lutIdx]))
      else $error("lookup position wrong");

   frame_wrap_c: cover property (adcReq_q.valid && adcReq_q.ch == CH_LAST);
   alarm_seen_c: cover property (|flags_q.aHi ##1 !faultOpenDrainOe_n ##1 faultOpenDrainOe_n);
   lut_mode_c: cover property (ctrlTen_q && lutIdx == LUT_LAST);
endmodule
`default_nettype wire

// [core/mrlf_pkg.sv]
// constants and carriers for the monitor result and limit flag block
package mrlf_pkg;
   localparam int NCH = 5;
   localparam logic [2:0] CH_TEMP = 3'h4;
   localparam logic [2:0] CH_LAST = 3'h4;
   localparam int CLK_HZ = 50_000_000;
   localparam int FRAME_TYP_MS = 47;
   localparam int FRAME_MAX_MS = 60;
   localparam int FRAME_CYC_TYP = FRAME_TYP_MS * (CLK_HZ / 1000);
   localparam int FRAME_CYC_MAX = FRAME_MAX_MS * (CLK_HZ / 1000);
   localparam logic [15:0] RES_MASK = 16'hfff8;
   localparam int ADDR_W = 12;
   localparam logic [2:0] PAGE_REG = 3'h0;
   localparam logic [2:0] PAGE_LUT0 = 3'h1;
   localparam logic [2:0] PAGE_LUT1 = 3'h2;
   localparam logic [2:0] GRP_CFG = 3'h0;
   localparam logic [2:0] GRP_RES = 3'h1;
   localparam logic [2:0] GRP_LIM = 3'h2;
   localparam logic [2:0] GRP_LIM_END = 3'h5;
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_STAT = 3'h1;
   localparam logic [2:0] IDX_FLAG = 3'h2;
   localparam logic [2:0] IDX_MAN = 3'h3;
   localparam logic [2:0] IDX_POS = 3'h4;
   localparam int CTRL_TEN_BIT = 0;
   localparam int CTRL_FEN_LSB = 8;
   localparam logic CTRL_TEN_RST = 1'b0;
   localparam logic [4:0] CTRL_FEN_RST = 5'h00;
   localparam logic [15:0] MAN_RST = 16'h0000;
   localparam logic [7:0] POS_RST = 8'h00;
   localparam logic [7:0] LUT_RST = 8'h00;
   localparam logic [15:0] RES_RST = 16'h0000;
   localparam logic [15:0] LIM_HI_U_RST = 16'hfff8;
   localparam logic [15:0] LIM_LO_U_RST = 16'h0000;
   localparam logic [15:0] LIM_HI_S_RST = 16'h7ff8;
   localparam logic [15:0] LIM_LO_S_RST = 16'h8000;
   localparam int LUT_N = 72;
   localparam logic [6:0] LUT_LAST = 7'h47;
   localparam logic [8:0] TEMP_OFS = 9'h028;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic valid;
      logic [2:0] ch;
   } mrlf_adc_req_s;

   typedef struct packed {
      logic valid;
      logic [15:0] code;
   } mrlf_adc_rsp_s;

   typedef struct packed {
      logic [4:0] aHi;
      logic [4:0] aLo;
      logic [4:0] wHi;
      logic [4:0] wLo;
   } mrlf_flags_s;

   // limit k: group k/5 (alarm hi, alarm lo, warn hi, warn lo), channel k%5
   function automatic logic [15:0] lim_rst(input int k);
      logic isTemp;
      logic isHi;
      isTemp = (k % NCH) == int'(CH_TEMP);
      isHi = ((k / NCH) % 2) == 0;
      if (isHi) begin
         lim_rst = isTemp ? LIM_HI_S_RST : LIM_HI_U_RST;
      end else begin
         lim_rst = isTemp ? LIM_LO_S_RST : LIM_LO_U_RST;
      end
   endfunction
endpackage

// [core/mrlf_cmp.sv]
// one channel's high and low limit comparison, signed or unsigned
`timescale 1ns/10ps
`default_nettype none
module mrlf_cmp (
   input wire logic [15:0] value, // masked channel result
   input wire logic isSigned, // two's complement channel
   input wire logic [15:0] aHiLim, // alarm high limit
   input wire logic [15:0] aLoLim, // alarm low limit
   input wire logic [15:0] wHiLim, // warning high limit
   input wire logic [15:0] wLoLim, // warning low limit
   output logic aHi, // above alarm high
   output logic aLo, // below alarm low
   output logic wHi, // above warning high
   output logic wLo // below warning low
);
   // flipping the sign bit turns a signed compare into an unsigned one
   wire logic [15:0] v = {value[15] ^ isSigned, value[14:0]};
   wire logic [15:0] ah = {aHiLim[15] ^ isSigned, aHiLim[14:0]};
   wire logic [15:0] al = {aLoLim[15] ^ isSigned, aLoLim[14:0]};
   wire logic [15:0] wh = {wHiLim[15] ^ isSigned, wHiLim[14:0]};
   wire logic [15:0] wl = {wLoLim[15] ^ isSigned, wLoLim[14:0]};
   assign aHi = v > ah;
   assign aLo = v < al;
   assign wHi = v > wh;
   assign wLo = v < wl;
endmodule
`default_nettype wire

// [tb/mrlf_adc_model.sv]
// converter model answering each request with the code set for its channel
`timescale 1ns/10ps
`default_nettype none
module mrlf_adc_model import mrlf_pkg::*; (
   input wire logic sys_clk, // clock
   input wire logic arst_n, // async reset
   input wire mrlf_adc_req_s adcReq, // request pulse
   input wire logic [4:0][15:0] codes, // raw code per channel
   output mrlf_adc_rsp_s adcRsp // response pulse
);
   logic [2:0] chQ;
   logic [2:0] cntQ;
   logic slowQ;
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         adcRsp <= '0;
         chQ <= 3'h0;
         cntQ <= 3'h0;
         slowQ <= 1'b0;
      end else begin
         adcRsp.valid <= 1'b0;
         // idle code keeps toggling so a stale value is never mistaken for data
         adcRsp.code <= ~adcRsp.code;
         if (adcReq.valid) begin
            chQ <= adcReq.ch;
            // alternate prompt and slow answers, both within one slot
            cntQ <= slowQ ? 3'h4 : 3'h1;
            slowQ <= ~slowQ;
         end else if (cntQ == 3'h1) begin
            adcRsp.valid <= 1'b1;
            adcRsp.code <= codes[chQ];
            cntQ <= 3'h0;
         end else if (cntQ != 3'h0) begin
            cntQ <= cntQ - 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the monitor result and limit flag block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin failures++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
   import mrlf_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic faultIn = 1'b0, losIn = 1'b0;
   logic faultOut, faultOe_n, losOut, losOe_n;
   logic [1:0][7:0] resPos;
   mrlf_adc_req_s adcReq;
   mrlf_adc_rsp_s adcRsp;
   logic [4:0][15:0] codes = {16'hf6ab, 16'h000f, 16'hffff, 16'h8000, 16'h1234};
   logic [2:0] nextCh = 3'h0;
   logic [15:0] gap = 16'h0;
   logic seen = 1'b0;
   int failures = 0;
   int testsRun = 0;
   always #10 sys_clk = ~sys_clk;
   mrlf_top #(.FRAME_CYCLES(50)) u_mrlf_top (.sys_clk(sys_clk), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .adcReq(adcReq), .adcRsp(adcRsp), .faultBufferIn(faultIn), .losBufferIn(losIn),
      .faultOpenDrainOut(faultOut), .faultOpenDrainOe_n(faultOe_n),
      .losOpenDrainOut(losOut), .losOpenDrainOe_n(losOe_n), .resPos(resPos));
   mrlf_adc_model u_mrlf_adc_model (.sys_clk(sys_clk), .arst_n(arst_n), .adcReq(adcReq),
      .codes(codes), .adcRsp(adcRsp));
   // request order and spacing monitor
   always @(posedge sys_clk) begin
      gap <= gap + 16'h1;
      if (arst_n && adcReq.valid) begin
         `CHK(adcReq.ch, nextCh)
         if (seen) `CHK(gap, 16'd10)
         seen <= 1'b1;
         gap <= 16'h1;
         nextCh <= (nextCh == CH_LAST) ? 3'h0 : nextCh + 3'h1;
      end
   end
   task automatic end_of_test;
      if (failures == 0 && testsRun > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
      if (n == 100) begin failures++; end_of_test(); end
      `CHK(bresp, er)
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge sys_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      if (n == 100) begin failures++; end_of_test(); end
      `CHK(rdata, ed)
      `CHK(rresp, er)
      rready <= 1'b0;
   endtask
   task automatic t_reset;
      rd(12'h000, 32'h0, RESP_OKAY);
      rd(12'h040, 32'h0000fff8, RESP_OKAY);
      rd(12'h050, 32'h00007ff8, RESP_OKAY);
      rd(12'h070, 32'h00008000, RESP_OKAY);
      rd(12'h0fc, 32'h0, RESP_SLVERR);
      wr(12'h0fc, 32'h1, RESP_SLVERR);
      wr(12'h008, 32'hffffffff, RESP_OKAY);
      rd(12'h008, 32'h0, RESP_OKAY);
      `CHK({faultOe_n, losOe_n, faultOut, losOut}, 4'h0)
   endtask
   task automatic t_results;
      int n;
      wr(12'h004, 32'h0000001f, RESP_OKAY);
      repeat (120) @(posedge sys_clk);
      rd(12'h004, 32'h0000001f, RESP_OKAY);
      for (n = 0; n < NCH; n++) begin
         rd(12'h020 + 12'(4 * n), {16'h0, codes[n] & RES_MASK}, RESP_OKAY);
      end
   endtask
   task automatic t_flags;
      // host limits carry only the upper thirteen bits, low three zero
      wr(12'h044, 32'h4000, RESP_OKAY);
      wr(12'h084, 32'h4000, RESP_OKAY);
      wr(12'h070, 32'h0000, RESP_OKAY);
      repeat (120) @(posedge sys_clk);
      // ch1 above both highs, temperature -10 below a zero alarm low
      rd(12'h008, 32'h00021002, RESP_OKAY);
   endtask
   task automatic t_pins;
      `CHK(faultOe_n, 1'b0)
      wr(12'h000, 32'h0200, RESP_OKAY);
      repeat (5) @(posedge sys_clk);
      `CHK(faultOe_n, 1'b1)
      wr(12'h000, 32'h0000, RESP_OKAY);
      repeat (5) @(posedge sys_clk);
      `CHK(faultOe_n, 1'b0)
      faultIn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      `CHK({faultOe_n, losOe_n}, 2'b10)
      faultIn <= 1'b0;
      losIn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      `CHK({faultOe_n, losOe_n, faultOut, losOut}, 4'h4)
      losIn <= 1'b0;
   endtask
   task automatic t_resistors;
      wr(12'h00c, 32'h5aa5, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      `CHK(resPos, 16'h5aa5)
      rd(12'h010, 32'h5aa5, RESP_OKAY);
      // -10 degrees selects table entry 15
      wr(12'h23c, 32'h3c, RESP_OKAY);
      wr(12'h43c, 32'hc3, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      `CHK(resPos, 16'h5aa5)
      wr(12'h000, 32'h0001, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      `CHK(resPos, 16'hc33c)
      wr(12'h000, 32'h0000, RESP_OKAY);
      repeat (3) @(posedge sys_clk);
      `CHK(resPos, 16'h5aa5)
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      arst_n <= 1'b1;
      t_reset();
      t_results();
      t_flags();
      t_pins();
      t_resistors();
      end_of_test();
   end
endmodule
`default_nettype wire
